// [design/rssm_pkg.sv]
/*
  constants, register map and status selector codes for the reference
  selection and status multiplexer block.
  assumes a 100 MHz core clock and a simple byte-wide register port.
*/
package rssm_pkg;

  // register port geometry
  localparam int          RSSM_ADDR_W      = 10;
  localparam int          RSSM_DATA_W      = 8;

  // register offsets
  localparam logic [9:0]  RSSM_OFS_STATSEL = 10'h017;  // status selector in [7:2]
  localparam logic [9:0]  RSSM_OFS_REFCTL  = 10'h01C;  // reference input control
  localparam logic [9:0]  RSSM_OFS_AUXCTL  = 10'h01D;  // bit 7: memory status override
  localparam logic [9:0]  RSSM_OFS_STATE   = 10'h01F;  // read-only selection state

  // values after reset
  localparam logic [7:0]  RSSM_RST_STATSEL = 8'h00;
  localparam logic [7:0]  RSSM_RST_REFCTL  = 8'h00;
  localparam logic [7:0]  RSSM_RST_AUXCTL  = 8'h80;

  // reference control, override and status selector field positions
  localparam int          RSSM_B_NODEGL    = 7;
  localparam int          RSSM_B_SELSEC    = 6;
  localparam int          RSSM_B_USEPIN    = 5;
  localparam int          RSSM_B_AUTO      = 4;
  localparam int          RSSM_B_STAY      = 3;
  localparam int          RSSM_B_PWRSEC    = 2;
  localparam int          RSSM_B_PWRPRI    = 1;
  localparam int          RSSM_B_DIFF      = 0;
  localparam int          RSSM_B_OVERRIDE  = 7;
  localparam int          RSSM_SEL_LSB     = 2;   // selector field low bit in 0x017
  localparam int          RSSM_POL_BIT     = 5;   // selector top bit: polarity

  // status selector function codes (low five bits)
  localparam logic [4:0]  RSSM_F_GROUND    = 5'h00;
  localparam logic [4:0]  RSSM_F_SELSTAT   = 5'h05;
  localparam logic [4:0]  RSSM_F_UNSSTAT   = 5'h06;
  localparam logic [4:0]  RSSM_F_PRIVALID  = 5'h07;
  localparam logic [4:0]  RSSM_F_SECVALID  = 5'h08;
  localparam logic [4:0]  RSSM_F_BOTHREF   = 5'h09;
  localparam logic [4:0]  RSSM_F_ALLGOOD   = 5'h0A;
  localparam logic [4:0]  RSSM_F_VCOVALID  = 5'h0B;
  localparam logic [4:0]  RSSM_F_SELREF    = 5'h0C;
  localparam logic [4:0]  RSSM_F_LOCK      = 5'h0D;
  localparam logic [4:0]  RSSM_F_HOLDOVER  = 5'h0E;
  localparam logic [4:0]  RSSM_F_RESERVED  = 5'h1F;

  // deglitch quiet time around a source change
  localparam int          RSSM_CLK_NS      = 10;
  localparam int          RSSM_DEGL_NS     = 50;
  localparam int          RSSM_DEGL_CYC    = (RSSM_DEGL_NS + RSSM_CLK_NS - 1) / RSSM_CLK_NS;

  // asynchronous inputs, one synchroniser lane each
  localparam int          RSSM_NSYNC       = 7;
  localparam int          RSSM_I_PRI       = 0;
  localparam int          RSSM_I_SEC       = 1;
  localparam int          RSSM_I_VCO       = 2;
  localparam int          RSSM_I_LOCK      = 3;
  localparam int          RSSM_I_HOLD      = 4;
  localparam int          RSSM_I_MEM       = 5;
  localparam int          RSSM_I_PIN       = 6;

  // switchover sequencer states
  typedef enum logic [1:0] {
    RSSM_RUN,
    RSSM_QUIET,
    RSSM_SETTLE
  } rssm_state_type;

endpackage

// [design/rssm_status_if.sv]
/*
  carrier between the control logic and the status pin multiplexer.
  assumes both ends share the block clock; the mux end is combinational.
*/
`timescale 1ns/1ns
interface rssm_status_if;
  logic [5:0] code;          // status selector field
  logic       pri_ok;        // primary reference valid
  logic       sec_ok;        // secondary reference valid
  logic       vco_ok;        // oscillator frequency valid
  logic       lock;          // digital lock indication
  logic       holdover;      // holdover active
  logic       sel_sec;       // secondary reference in use
  logic       diff;          // differential reference mode
  logic       mem_stat;      // configuration memory status
  logic       override;      // memory status takes the pin
  logic       level;         // resulting pin level

  modport ctl (output code, pri_ok, sec_ok, vco_ok, lock, holdover,
               output sel_sec, diff, mem_stat, override, input level);
  modport mux (input code, pri_ok, sec_ok, vco_ok, lock, holdover,
               input sel_sec, diff, mem_stat, override, output level);
endinterface

// [design/rssm_status_mux.sv]
/*
  status pin multiplexer: picks one monitored flag by selector code.
  assumes synchronised flags; output is registered by the instantiating module.
*/
`timescale 1ns/1ns
module rssm_status_mux
  import rssm_pkg::*;
(
  // carrier from control logic
  rssm_status_if.mux st
);

  // raw active-high function value, before polarity
  function automatic logic rssm_raw(input logic [4:0] f, input logic pri, input logic sec,
                                    input logic vco, input logic lk, input logic ho,
                                    input logic ss, input logic df);
    logic selst;
    logic unsst;
    selst = (ss && !df) ? sec : pri;   // differential uses the primary input
    unsst = df ? 1'b0 : (ss ? pri : sec);
    case (f)
      RSSM_F_SELSTAT:  rssm_raw = selst;
      RSSM_F_UNSSTAT:  rssm_raw = unsst;
      RSSM_F_PRIVALID: rssm_raw = pri;
      RSSM_F_SECVALID: rssm_raw = sec;
      RSSM_F_VCOVALID: rssm_raw = vco;
      RSSM_F_SELREF:   rssm_raw = ss;
      RSSM_F_LOCK:     rssm_raw = lk;
      RSSM_F_HOLDOVER: rssm_raw = ho;
      default:         rssm_raw = 1'b0;  // ground and clock codes
    endcase
  endfunction

  // pin level selection
  always_comb begin
    logic [4:0] f;
    logic       inv;
    f   = st.code[4:0];
    inv = st.code[RSSM_POL_BIT];
    if (st.override) begin
      st.level = st.mem_stat;
    end else if (f == RSSM_F_RESERVED) begin
      st.level = 1'b0;
    end else if (f == RSSM_F_BOTHREF) begin
      st.level = st.pri_ok && st.sec_ok;
    end else if (f == RSSM_F_ALLGOOD) begin
      // lock, oscillator and selected reference valid, ignoring polarity by design
      st.level = st.lock && st.vco_ok &&
                 ((st.sel_sec && !st.diff) ? st.sec_ok : st.pri_ok);
    end else begin
      // top code bit inverts every other function
      st.level = inv ^ rssm_raw(f, st.pri_ok, st.sec_ok, st.vco_ok, st.lock,
                                st.holdover, st.sel_sec, st.diff);
    end
  end

endmodule // rssm_status_mux

// [design/rssm_top.sv]
/*
  reference selection control and status pin multiplexer.
  holds the reference control, status selector and override registers,
  drives reference power enables, the selected source and a gate that
  keeps the loop input quiet while the source changes.
  assumes a byte-wide register port on the core clock and asynchronous
  monitor flags and select pin, which are synchronised here.
*/
`timescale 1ns/1ns
module rssm_top
  import rssm_pkg::*;
#(
  parameter int DEGL_CYCLES = RSSM_DEGL_CYC   // quiet cycles on each side of a switch
)(
  // clock and reset
  input  wire logic                   clk_in,
  input  wire logic                   resetn_in,
  // register port
  input  wire logic                   reg_wr_in,
  input  wire logic [RSSM_ADDR_W-1:0] reg_addr_in,
  input  wire logic [RSSM_DATA_W-1:0] reg_wdata_in,
  output      logic [RSSM_DATA_W-1:0] reg_rdata_out,
  // pins and monitor flags, asynchronous
  input  wire logic                   ref_sel_pin_in,
  input  wire logic                   pri_valid_in,
  input  wire logic                   sec_valid_in,
  input  wire logic                   vco_valid_in,
  input  wire logic                   lock_in,
  input  wire logic                   holdover_in,
  input  wire logic                   mem_status_in,
  // reference path control
  output      logic                   ref_select_out,
  output      logic                   ref_gate_out,
  output      logic                   pri_power_out,
  output      logic                   sec_power_out,
  output      logic                   diff_mode_out,
  // status pin
  output      logic                   status_pin_out
);

  // counter must hold the quiet time; a zero count would wrap the reload to 15, giving 16 cycles a side
  if (DEGL_CYCLES < 1 || DEGL_CYCLES > 15) begin : g_degl_check
    $error("rssm_top: DEGL_CYCLES must be 1..15");
  end

  // whole module state
  typedef struct packed {
    logic [RSSM_NSYNC-1:0]  sync1;     // first synchroniser stage
    logic [RSSM_NSYNC-1:0]  sync2;     // second synchroniser stage
    logic [7:0]             refctl;    // reference input control
    logic [7:0]             statsel;   // status selector register
    logic [7:0]             auxctl;    // override register
    rssm_state_type         state;     // switchover sequencer
    logic [3:0]             count;     // quiet time counter
    logic                   sel_sec;   // secondary source in use
    logic                   gate;      // loop input enabled
    logic                   pri_pwr;   // primary input power
    logic                   sec_pwr;   // secondary input power
    logic                   diff;      // differential mode
    logic                   status;    // registered pin level
    logic [7:0]             rdata;     // registered read data
  } rssm_regs_type;

  rssm_regs_type r;                    // current state
  rssm_regs_type next_r;               // next state
  rssm_status_if st ();                // carrier to the status mux
  logic          want_sec;             // requested source
  logic [3:0]    degl_load;            // counter reload value

  assign degl_load = 4'(DEGL_CYCLES - 1);

  // status pin multiplexer
  rssm_status_mux u_mux (
    .st (st.mux)
  );

  // feed the mux from synchronised flags and current selection
  assign st.code     = r.statsel[7:RSSM_SEL_LSB];
  assign st.pri_ok   = r.sync2[RSSM_I_PRI];
  assign st.sec_ok   = r.sync2[RSSM_I_SEC];
  assign st.vco_ok   = r.sync2[RSSM_I_VCO];
  assign st.lock     = r.sync2[RSSM_I_LOCK];
  assign st.holdover = r.sync2[RSSM_I_HOLD];
  assign st.sel_sec  = r.sel_sec;
  assign st.diff     = r.diff;
  assign st.mem_stat = r.sync2[RSSM_I_MEM];
  assign st.override = r.auxctl[RSSM_B_OVERRIDE];

  // requested source from mode bits and reference health
  always_comb begin
    logic pri_ok;
    logic sec_ok;
    pri_ok = r.sync2[RSSM_I_PRI];
    sec_ok = r.sync2[RSSM_I_SEC];
    if (r.refctl[RSSM_B_DIFF]) begin
      // differential reference arrives on the primary input
      want_sec = 1'b0;
    end else if (r.refctl[RSSM_B_AUTO]) begin
      // mode bit 0 is expected clear here; the diff branch wins otherwise
      if (!r.sel_sec) begin
        // leave primary only for a healthy secondary
        want_sec = !pri_ok && sec_ok;
      end else if (pri_ok && !r.refctl[RSSM_B_STAY]) begin
        want_sec = 1'b0;
      end else begin
        want_sec = 1'b1;
      end
    end else if (r.refctl[RSSM_B_USEPIN]) begin
      want_sec = r.sync2[RSSM_I_PIN];
    end else begin
      want_sec = r.refctl[RSSM_B_SELSEC];
    end
  end

  // next state
  always_comb begin
    next_r = r;

    // two-stage synchronisers; stage one feeds stage two only
    next_r.sync1 = {ref_sel_pin_in, mem_status_in, holdover_in, lock_in,
                    vco_valid_in, sec_valid_in, pri_valid_in};
    next_r.sync2 = r.sync1;

    // register writes
    if (reg_wr_in) begin
      if (reg_addr_in == RSSM_OFS_REFCTL) begin
        next_r.refctl = reg_wdata_in;
      end else if (reg_addr_in == RSSM_OFS_STATSEL) begin
        // low two bits belong to other functions; kept as written
        next_r.statsel = reg_wdata_in;
      end else if (reg_addr_in == RSSM_OFS_AUXCTL) begin
        // only the override bit is implemented here
        next_r.auxctl = {reg_wdata_in[RSSM_B_OVERRIDE], 7'h00};
      end
    end

    // read data, registered one cycle after the address
    if (reg_addr_in == RSSM_OFS_REFCTL) begin
      next_r.rdata = r.refctl;
    end else if (reg_addr_in == RSSM_OFS_STATSEL) begin
      next_r.rdata = r.statsel;
    end else if (reg_addr_in == RSSM_OFS_AUXCTL) begin
      next_r.rdata = r.auxctl;
    end else if (reg_addr_in == RSSM_OFS_STATE) begin
      // live selection state, not writable
      next_r.rdata = {4'h0, r.state != RSSM_RUN, r.gate, r.diff, r.sel_sec};
    end else begin
      next_r.rdata = 8'h00;            // unmapped reads as zero
    end

    // power enables; automatic mode forces both on
    if (r.refctl[RSSM_B_AUTO]) begin
      next_r.pri_pwr = 1'b1;
      next_r.sec_pwr = 1'b1;
    end else begin
      next_r.pri_pwr = r.refctl[RSSM_B_PWRPRI];
      next_r.sec_pwr = r.refctl[RSSM_B_PWRSEC];
    end
    // power bits are not masked in differential mode; software clears them
    next_r.diff = r.refctl[RSSM_B_DIFF];

    // switchover sequencer
    case (r.state)
      RSSM_RUN: begin
        if (want_sec != r.sel_sec) begin
          if (r.refctl[RSSM_B_NODEGL]) begin
            // deglitch off: switch at once, glitches possible
            next_r.sel_sec = want_sec;
          end else begin
            // close the gate first so no partial cycle leaks
            next_r.gate  = 1'b0;
            next_r.count = degl_load;
            next_r.state = RSSM_QUIET;
          end
        end
      end
      RSSM_QUIET: begin
        if (r.count == 4'h0) begin
          // change source while the gate is closed
          next_r.sel_sec = want_sec;
          next_r.count   = degl_load;
          next_r.state   = RSSM_SETTLE;
        end else begin
          next_r.count = r.count - 4'h1;
        end
      end
      RSSM_SETTLE: begin
        if (r.count == 4'h0) begin
          // new source has settled; reopen the gate
          next_r.gate  = 1'b1;
          next_r.state = RSSM_RUN;
        end else begin
          next_r.count = r.count - 4'h1;
        end
      end
      default: begin
        next_r.state = RSSM_RUN;
        next_r.gate  = 1'b1;
      end
    endcase

    // status pin level, registered
    next_r.status = st.level;
  end

  // state register
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      r.sync1   <= '0;
      r.sync2   <= '0;
      r.refctl  <= RSSM_RST_REFCTL;
      r.statsel <= RSSM_RST_STATSEL;
      r.auxctl  <= RSSM_RST_AUXCTL;
      r.state   <= RSSM_RUN;
      r.count   <= 4'h0;
      r.sel_sec <= 1'b0;
      r.gate    <= 1'b1;
      r.pri_pwr <= 1'b0;
      r.sec_pwr <= 1'b0;
      r.diff    <= 1'b0;
      r.status  <= 1'b0;
      r.rdata   <= 8'h00;
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from flip-flops
  assign reg_rdata_out  = r.rdata;
  assign ref_select_out = r.sel_sec;
  assign ref_gate_out   = r.gate;
  assign pri_power_out  = r.pri_pwr;
  assign sec_power_out  = r.sec_pwr;
  assign diff_mode_out  = r.diff;
  assign status_pin_out = r.status;

endmodule // rssm_top

// [sim/rssm_props.sv]
/* checker for rssm_top: shadow copies of the registers and synchronisers,
   then relations between the port signals.
   assumes single clock clk_in and async active-low resetn_in. */
`timescale 1ns/1ns
module rssm_props
  import rssm_pkg::*;
#(
  parameter int DEGL_CYCLES = RSSM_DEGL_CYC   // quiet cycles each side of a switch
)(
  // clock, reset, register port
  input wire logic                   clk_in,
  input wire logic                   resetn_in,
  input wire logic                   reg_wr_in,
  input wire logic [RSSM_ADDR_W-1:0] reg_addr_in,
  input wire logic [RSSM_DATA_W-1:0] reg_wdata_in,
  input wire logic [RSSM_DATA_W-1:0] reg_rdata_out,
  // monitor flags
  input wire logic                   pri_valid_in,
  input wire logic                   sec_valid_in,
  input wire logic                   vco_valid_in,
  input wire logic                   lock_in,
  input wire logic                   holdover_in,
  input wire logic                   mem_status_in,
  // design outputs
  input wire logic                   ref_select_out,
  input wire logic                   ref_gate_out,
  input wire logic                   pri_power_out,
  input wire logic                   sec_power_out,
  input wire logic                   diff_mode_out,
  input wire logic                   status_pin_out
);
  logic [7:0] ctl_q;    // shadow of reference control
  logic [5:0] code_q;   // shadow of status selector
  logic       ovr_q;    // shadow of memory status override
  logic [5:0] s1, s2;   // two-stage copies of the flags
  logic       v, e, ek; // expected pin level, and whether it is known
  int         lowcnt;   // cycles the loop gate has been closed
  // shadows follow the same write edge as the design
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ctl_q  <= RSSM_RST_REFCTL;
      code_q <= RSSM_RST_STATSEL[7:2];
      ovr_q  <= RSSM_RST_AUXCTL[7];
      s1     <= 6'h00;
      s2     <= 6'h00;
      lowcnt <= 0;
    end else begin
      if (reg_wr_in && reg_addr_in == RSSM_OFS_REFCTL) ctl_q <= reg_wdata_in;
      if (reg_wr_in && reg_addr_in == RSSM_OFS_STATSEL) code_q <= reg_wdata_in[7:2];
      if (reg_wr_in && reg_addr_in == RSSM_OFS_AUXCTL) ovr_q <= reg_wdata_in[7];
      s1     <= {mem_status_in, holdover_in, lock_in, vco_valid_in, sec_valid_in, pri_valid_in};
      s2     <= s1;
      lowcnt <= ref_gate_out ? 0 : lowcnt + 1;
    end
  end
  // codes that do not depend on the selected source only
  always_comb begin
    ek = 1'b1;
    case (code_q[4:0])
      RSSM_F_PRIVALID: v = s2[0];
      RSSM_F_SECVALID: v = s2[1];
      RSSM_F_BOTHREF:  v = s2[0] & s2[1];
      RSSM_F_VCOVALID: v = s2[2];
      RSSM_F_LOCK:     v = s2[3];
      RSSM_F_HOLDOVER: v = s2[4];
      RSSM_F_GROUND:   v = 1'b0;
      RSSM_F_RESERVED: v = 1'b0;
      default: begin
        v  = 1'b0;
        ek = 1'b0;
      end
    endcase
    // static AND and reserved codes are not inverted
    if (code_q[4:0] != RSSM_F_BOTHREF && code_q[4:0] != RSSM_F_RESERVED) v = v ^ code_q[5];
    e  = ovr_q ? s2[5] : v;
    ek = ek | ovr_q;
  end
  a_status_follow: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $past(ek) |-> status_pin_out == $past(e)) else $error("status pin level wrong");
  a_power_enables: assert property (@(posedge clk_in) disable iff (!resetn_in)
    {sec_power_out, pri_power_out} == ($past(ctl_q[2:1]) | {2{$past(ctl_q[4])}}))
    else $error("reference power enables wrong");
  a_diff_mode: assert property (@(posedge clk_in) disable iff (!resetn_in)
    diff_mode_out == $past(ctl_q[0])) else $error("differential mode wrong");
  a_read_refctl: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $past(reg_addr_in) == RSSM_OFS_REFCTL |-> reg_rdata_out == $past(ctl_q))
    else $error("reference control read wrong");
  a_select_gated: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $changed(ref_select_out) && !$past(ctl_q[7]) |-> !ref_gate_out)
    else $error("source changed with gate open");
  a_gate_length: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $rose(ref_gate_out) |-> lowcnt >= 2*DEGL_CYCLES-1 && lowcnt <= 2*DEGL_CYCLES+2)
    else $error("gate quiet time wrong");
  a_nodegl_gate: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ctl_q[7] && $past(ctl_q[7]) && $past(ref_gate_out) |-> ref_gate_out)
    else $error("gate closed with deglitch off");
  a_reg_select: assert property (@(posedge clk_in) disable iff (!resetn_in)
    ctl_q == $past(ctl_q, 3) && ctl_q[7] && ctl_q[5:4] == 2'b00 && !ctl_q[0]
    |-> ref_select_out == ctl_q[6]) else $error("register select not followed");
endmodule // rssm_props

bind rssm_top rssm_props #(.DEGL_CYCLES(DEGL_CYCLES)) rssm_props_inst (
  .clk_in(clk_in), .resetn_in(resetn_in), .reg_wr_in(reg_wr_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .pri_valid_in(pri_valid_in), .sec_valid_in(sec_valid_in), .vco_valid_in(vco_valid_in),
  .lock_in(lock_in), .holdover_in(holdover_in), .mem_status_in(mem_status_in),
  .ref_select_out(ref_select_out), .ref_gate_out(ref_gate_out),
  .pri_power_out(pri_power_out), .sec_power_out(sec_power_out),
  .diff_mode_out(diff_mode_out), .status_pin_out(status_pin_out));

// [sim/rssm_ref_model.sv]
/* reference sources, monitors, memory status and select pin.
   assumes the bench names the wanted levels; they move 1 ns after an edge. */
`timescale 1ns/1ns
module rssm_ref_model (
  // clock and wanted levels {pin, mem, hold, lock, vco, sec, pri}
  input  wire logic       clk_in,
  input  wire logic [6:0] want_in,
  // levels seen by the block
  output      logic [6:0] level_out
);
  // levels start low, like sources not yet valid
  initial level_out = 7'h00;
  // all flags change together, unrelated to the register port
  always @(posedge clk_in) begin
    level_out <= #1 want_in;
  end
endmodule // rssm_ref_model

// [sim/tb_top.sv]
/* self-checking bench for rssm_top with the reference model.
   assumes rssm_props is bound to rssm_top. */
`timescale 1ns/1ns
module tb_top;
  import rssm_pkg::*;
  localparam int D = 3;       // short quiet time keeps the run brief
  logic       clk    = 1'b0;  // core clock
  logic       resetn = 1'b0;  // reset, active low
  logic       wr     = 1'b0;  // write strobe
  logic [9:0] addr   = 10'h000;
  logic [7:0] wdata  = 8'h00;
  logic [7:0] rdata, rv;      // read data, read result
  logic [6:0] want   = 7'h00; // {pin, mem, hold, lock, vco, sec, pri}
  logic [6:0] lvl;            // model levels
  logic       sel, gate, pp, spw, dm, pin;
  int         n_fail = 0;
  int         checked = 0;
  int         cyc = 0;
  int         k;
  always #5 clk = ~clk;
  rssm_top #(.DEGL_CYCLES(D)) rssm_top_inst (
    .clk_in(clk), .resetn_in(resetn), .reg_wr_in(wr), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .ref_sel_pin_in(lvl[6]),
    .pri_valid_in(lvl[0]), .sec_valid_in(lvl[1]), .vco_valid_in(lvl[2]),
    .lock_in(lvl[3]), .holdover_in(lvl[4]), .mem_status_in(lvl[5]),
    .ref_select_out(sel), .ref_gate_out(gate), .pri_power_out(pp),
    .sec_power_out(spw), .diff_mode_out(dm), .status_pin_out(pin));
  rssm_ref_model rssm_ref_model_inst (.clk_in(clk), .want_in(want), .level_out(lvl));
  // one comparison, counted
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe, data held with it
  task automatic wr_reg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(posedge clk);
    #1;
    wr = 1'b0;
  endtask
  // registered read: data one edge after the address
  task automatic rd_reg(input logic [9:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    @(posedge clk);
    #1 d = rdata;
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // pin level from code, flags and source in use
  function automatic logic ex_pin(input logic [5:0] c, input logic [6:0] f, input logic s);
    logic v;
    case (c[4:0])
      RSSM_F_PRIVALID: v = f[0];
      RSSM_F_SECVALID: v = f[1];
      RSSM_F_BOTHREF:  v = f[0] & f[1];
      RSSM_F_ALLGOOD:  v = f[3] & (s ? f[1] : f[0]) & f[2];
      RSSM_F_VCOVALID: v = f[2];
      RSSM_F_SELREF:   v = s;
      RSSM_F_LOCK:     v = f[3];
      RSSM_F_HOLDOVER: v = f[4];
      default:         v = 1'b0;
    endcase
    if (c[4:0] == RSSM_F_BOTHREF || c[4:0] == RSSM_F_ALLGOOD || c[4:0] == RSSM_F_RESERVED)
      return v;
    return v ^ c[5];
  endfunction
  // every level code except selected and unselected status against four flag patterns
  task automatic sweep(input logic s);
    logic [5:0] codes [12] = '{6'h27, 6'h28, 6'h29, 6'h2A, 6'h2B, 6'h2C, 6'h2D, 6'h2E,
                               6'h3F, 6'h20, 6'h07, 6'h0C};
    logic [6:0] pats [4] = '{7'h00, 7'h1F, 7'h05, 7'h1A};
    foreach (codes[i]) begin
      foreach (pats[j]) begin
        want = pats[j];
        wr_reg(RSSM_OFS_STATSEL, {codes[i], 2'b00});
        wt(4);
        chk("status pin", 8'(pin), 8'(ex_pin(codes[i], pats[j], s)));
      end
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // hang guard, far above the roughly 700 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    wt(10);
    resetn = 1'b1;
    rd_reg(RSSM_OFS_REFCTL, rv);
    chk("refctl reset", rv, RSSM_RST_REFCTL);
    rd_reg(RSSM_OFS_STATSEL, rv);
    chk("statsel reset", rv, RSSM_RST_STATSEL);
    rd_reg(RSSM_OFS_AUXCTL, rv);
    chk("auxctl reset", rv, RSSM_RST_AUXCTL);
    want = 7'h20;
    wt(5);
    chk("memory status", 8'(pin), 8'h01);
    // write, then refused writes leave it alone on read back
    wr_reg(RSSM_OFS_REFCTL, 8'h86);
    wr_reg(RSSM_OFS_STATE, 8'hFF);
    wr_reg(10'h3FF, 8'hFF);
    rd_reg(RSSM_OFS_REFCTL, rv);
    chk("refctl", rv, 8'h86);
    rd_reg(10'h3FF, rv);
    chk("unmapped read", rv, 8'h00);
    chk("powers", 8'({spw, pp, dm}), 8'h06);
    wr_reg(RSSM_OFS_AUXCTL, 8'h7F);
    rd_reg(RSSM_OFS_AUXCTL, rv);
    chk("auxctl bits", rv, 8'h00);
    sweep(1'b0);
    // deglitched switch to the secondary source
    wr_reg(RSSM_OFS_REFCTL, 8'h46);
    for (k = 0; k < 10 && gate !== 1'b0; k++) begin
      wt(1);
    end
    chk("gate closes", 8'(gate), 8'h00);
    wt(4*D+4);
    chk("select sec", 8'(sel), 8'h01);
    chk("gate open", 8'(gate), 8'h01);
    sweep(1'b1);
    // pin selection, deglitch off
    wr_reg(RSSM_OFS_REFCTL, 8'hA6);
    for (k = 0; k < 2; k++) begin
      want = {k[0], 6'h00};
      wt(6);
      chk("pin select", 8'(sel), 8'(k[0]));
      chk("gate held", 8'(gate), 8'h01);
    end
    // automatic switchover, single-ended mode kept
    want = 7'h07;
    wr_reg(RSSM_OFS_REFCTL, 8'h90);
    wt(8);
    chk("auto powers", 8'({spw, pp}), 8'h03);
    for (k = 0; k < 2; k++) begin
      wr_reg(RSSM_OFS_REFCTL, k[0] ? 8'h98 : 8'h90);
      want = 7'h06;
      wt(8);
      chk("to secondary", 8'(sel), 8'h01);
      want = 7'h07;
      wt(8);
      chk("revert", 8'(sel), 8'(k[0]));
    end
    // differential mode with power bits cleared
    wr_reg(RSSM_OFS_REFCTL, 8'h81);
    wt(6);
    chk("diff mode", 8'({sel, spw, pp, dm}), 8'h01);
    rd_reg(RSSM_OFS_STATE, rv);
    chk("state read", rv, 8'h06);
    // second reset in mid-run
    resetn = 1'b0;
    wt(3);
    resetn = 1'b1;
    rd_reg(RSSM_OFS_REFCTL, rv);
    chk("refctl again", rv, RSSM_RST_REFCTL);
    summarize();
  end
endmodule // tb_top
